// >>> shared/three_port_gpio_params.svh
`ifndef THREE_PORT_GPIO_PARAMS_SVH
`define THREE_PORT_GPIO_PARAMS_SVH

// Register indexes; byte address is four times the index
`define IDX_FIRST_PORT_DATA     8'h05
`define IDX_SECOND_PORT_DATA    8'h06
`define IDX_THIRD_PORT_DATA     8'h07
`define IDX_INTERRUPT_CONTROL   8'h0B
`define IDX_OPTION_SETTINGS     8'h81
`define IDX_FIRST_PORT_DIR      8'h85
`define IDX_SECOND_PORT_DIR     8'h86
`define IDX_THIRD_PORT_DIR      8'h87
`define IDX_CONVERTER_CTRL_ONE  8'h9F

// Reset values
`define RST_OPTION_SETTINGS     8'hFF
`define RST_FIRST_PORT_DIR      8'h3F
`define RST_SECOND_PORT_DIR     8'hFF
`define RST_THIRD_PORT_DIR      8'hFF
`define RST_PIN_ANALOG_SELECT   3'h0
`define RST_PORT_LATCH          8'h00

// Field positions
`define BIT_PULLUP_DISABLE_N    7
`define BIT_PORT_CHANGE_FLAG    0
`define BIT_PORT_CHANGE_ENABLE  3
`define BIT_TIMER_CLOCK_PIN     4
`define BIT_SLAVE_SELECT_PIN    5
`define BIT_EXTERNAL_IRQ_PIN    0
`define FIRST_PORT_MASK         8'h3F
`define KEEP_MASK_LSB           8
`define PIN_ANALOG_CODE_ALL_DIG 3'h5

`endif

// >>> shared/three_port_gpio_pkg.sv
package three_port_gpio_pkg;

    typedef logic [7:0] port_t;

    // Drive of one 8-bit port: output level and active-low output enable
    typedef struct packed {
        port_t out;
        port_t oe_n;
    } port_drive_s;

    // Peripheral claim on the third port
    typedef struct packed {
        port_t sel;
        port_t out;
        port_t oe;
    } periph_claim_s;

endpackage

// >>> testbench/gpio_pin_model.sv
`timescale 1ns/10ps

module gpio_pin_model
    import three_port_gpio_pkg::*;
(
    // Clock
    input  wire logic        pclk,
    // Device side
    input  wire port_drive_s drive,
    input  wire port_t       pull_on,
    // Far-side drivers
    input  wire port_t       ext,
    input  wire port_t       ext_en,
    // Resolved pin levels
    output port_t            pin
);
    port_t float_ff = 8'h00;

    // Undriven pins without pull-up show the inverse of their last level
    always_ff @(posedge pclk) begin
        float_ff <= ~pin;
    end

    // Device drive wins, then the far driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!drive.oe_n[i]) begin
                pin[i] = drive.out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext[i];
            end else if (pull_on[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_ff[i];
            end
        end
    end
endmodule

// >>> testbench/three_port_gpio_tb.sv
`timescale 1ns/10ps
`include "three_port_gpio_params.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end

module three_port_gpio_tb
    import three_port_gpio_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, sleep_mode;
    logic          pready, pslverr, timer_clock_pin, slave_select_pin, external_irq_pin;
    logic          port_change_flag, wake_req;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic [3:0]    pstrb;
    port_t         pa, pb, pc, pb_pull, periph_in, ext_a, ext_b, ext_c, en_a, en_b, en_c;
    port_drive_s   da, db, dc;
    periph_claim_s claim;
    int            fail_count = 0;
    int            compares = 0;
    logic [7:0]    exp_q[$];

    three_port_gpio dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_port_in(pa), .first_port_drive(da), .second_port_in(pb), .second_port_drive(db),
        .second_port_pullup(pb_pull), .third_port_in(pc), .third_port_drive(dc), .third_port_claim(claim),
        .timer_clock_pin(timer_clock_pin), .slave_select_pin(slave_select_pin),
        .external_irq_pin(external_irq_pin), .third_port_periph_in(periph_in), .sleep_mode(sleep_mode),
        .port_change_flag(port_change_flag), .wake_req(wake_req));
    gpio_pin_model pin_a (.pclk(pclk), .drive(da), .pull_on(8'h00), .ext(ext_a), .ext_en(en_a), .pin(pa));
    gpio_pin_model pin_b (.pclk(pclk), .drive(db), .pull_on(pb_pull), .ext(ext_b), .ext_en(en_b), .pin(pb));
    gpio_pin_model pin_c (.pclk(pclk), .drive(dc), .pull_on(8'h00), .ext(ext_c), .ext_en(en_c), .pin(pc));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic end_of_test();
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd, input logic [3:0] st,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            fail_count++;
            end_of_test();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, {2'b00, idx, 2'b00}, {8'h00, d}, 4'h1, r, e);
    endtask

    task automatic rreg(input logic [7:0] idx, output logic [7:0] d);
        logic e;
        apb(1'b0, {2'b00, idx, 2'b00}, 16'h0000, 4'h0, d, e);
    endtask

    initial begin
        logic [7:0] rd, am, v;
        logic       err;
        int         nd, n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        claim = '0;
        sleep_mode = 1'b0;
        ext_a = 8'h3F;
        en_a = 8'hFF;
        ext_b = 8'h00;
        en_b = 8'hFF;
        ext_c = 8'h00;
        en_c = 8'hFF;
        v = 8'($urandom(24989));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("pullup_reset", 8'h00, pb_pull)
        `CHK("oe_n_reset", 8'hFF, da.oe_n)
        rreg(`IDX_FIRST_PORT_DIR, rd);
        `CHK("dir_a", 8'h3F, rd)
        rreg(`IDX_SECOND_PORT_DIR, rd);
        `CHK("dir_b", 8'hFF, rd)
        rreg(`IDX_OPTION_SETTINGS, rd);
        `CHK("option", 8'hFF, rd)
        rreg(`IDX_CONVERTER_CTRL_ONE, rd);
        `CHK("analog_cfg", 8'h00, rd)
        rreg(`IDX_FIRST_PORT_DATA, rd);
        `CHK("a_reset_read", 8'h10, rd)
        apb(1'b0, 12'h015, 16'h0000, 4'h0, rd, err);
        `CHK("unaligned_err", 1'b1, err)
        apb(1'b1, 12'h100, 16'h00FF, 4'h1, rd, err);
        `CHK("unmapped_err", 1'b1, err)
        // Every analog select code, analog pins read zero
        for (int c = 0; c < 8; c++) begin
            wreg(`IDX_CONVERTER_CTRL_ONE, c[7:0]);
            nd = (c < 5) ? 5 - c : 0;
            am = 8'h00;
            for (int k = 0; k < nd; k++) am[(k == 4) ? 5 : k] = 1'b1;
            rreg(`IDX_FIRST_PORT_DATA, rd);
            `CHK("analog_read", 8'h3F & ~am, rd)
        end
        // Port A outputs while pins 0..3 and 5 analog
        wreg(`IDX_CONVERTER_CTRL_ONE, 8'h00);
        en_a <= 8'h00;
        wreg(`IDX_FIRST_PORT_DATA, 8'h25);
        wreg(`IDX_FIRST_PORT_DIR, 8'h00);
        repeat (4) @(posedge pclk);
        `CHK("a_out", 8'h25, da.out)
        `CHK("a_oe_n", 8'hC0, da.oe_n)
        `CHK("timer_pin", 1'b0, timer_clock_pin)
        `CHK("ss_pin", 1'b1, slave_select_pin)
        wreg(`IDX_FIRST_PORT_DATA, 8'h35);
        repeat (4) @(posedge pclk);
        `CHK("a4_open_drain", 8'hD0, da.oe_n)
        `CHK("a4_never_high", 8'h25, da.out)
        // Read-modify-write through keep mask on port C
        ext_c <= 8'h50;
        en_c <= 8'hF0;
        wreg(`IDX_THIRD_PORT_DIR, 8'hF0);
        repeat (3) @(posedge pclk);
        apb(1'b1, {2'b00, `IDX_THIRD_PORT_DATA, 2'b00}, 16'hF00A, 4'h3, rd, err);
        en_c <= 8'h00;
        wreg(`IDX_THIRD_PORT_DIR, 8'h00);
        repeat (4) @(posedge pclk);
        `CHK("c_rmw", 8'h5A, dc.out)
        `CHK("c_oe_n", 8'h00, dc.oe_n)
        `CHK("c_periph_in", 8'h5A, periph_in)
        rreg(`IDX_THIRD_PORT_DATA, rd);
        `CHK("c_read", 8'h5A, rd)
        // Claim overrides data and direction on pins 0 and 1
        claim <= {8'h03, 8'h01, 8'h12};
        repeat (3) @(posedge pclk);
        `CHK("claim_out", 8'h59, dc.out)
        `CHK("claim_oe_n", 8'h01, dc.oe_n)
        claim <= '0;
        // Pull-ups
        wreg(`IDX_OPTION_SETTINGS, 8'h7F);
        wreg(`IDX_SECOND_PORT_DIR, 8'h0F);
        repeat (3) @(posedge pclk);
        `CHK("pullup_on", 8'h0F, pb_pull)
        wreg(`IDX_OPTION_SETTINGS, 8'hFF);
        repeat (3) @(posedge pclk);
        `CHK("pullup_off", 8'h00, pb_pull)
        // Random port B output values
        en_b <= 8'h00;
        wreg(`IDX_SECOND_PORT_DIR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            exp_q.push_back(v);
            wreg(`IDX_SECOND_PORT_DATA, v);
            repeat (4) @(posedge pclk);
            `CHK("b_out", v, db.out)
            `CHK("b_oe_n", 8'h00, db.oe_n)
            `CHK("irq_pin", v[0], external_irq_pin)
            rreg(`IDX_SECOND_PORT_DATA, rd);
            am = exp_q.pop_front();
            `CHK("b_read", am, rd)
        end
        // Change detection and wake
        ext_b <= 8'h00;
        en_b <= 8'hFF;
        wreg(`IDX_SECOND_PORT_DIR, 8'hFF);
        repeat (3) @(posedge pclk);
        rreg(`IDX_SECOND_PORT_DATA, rd);
        wreg(`IDX_INTERRUPT_CONTROL, 8'h08);
        repeat (3) @(posedge pclk);
        `CHK("flag_idle", 1'b0, port_change_flag)
        sleep_mode <= 1'b1;
        ext_b <= 8'h10;
        n = 0;
        while (port_change_flag !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
        end
        `CHK("flag_set", 1'b1, port_change_flag)
        repeat (2) @(posedge pclk);
        `CHK("wake", 1'b1, wake_req)
        wreg(`IDX_INTERRUPT_CONTROL, 8'h08);
        repeat (2) @(posedge pclk);
        `CHK("flag_held", 1'b1, port_change_flag)
        // One read to end the mismatch, no polling
        rreg(`IDX_SECOND_PORT_DATA, rd);
        wreg(`IDX_INTERRUPT_CONTROL, 8'h08);
        repeat (3) @(posedge pclk);
        `CHK("flag_clear", 1'b0, port_change_flag)
        sleep_mode <= 1'b0;
        // Output pin 7 is left out of the comparison
        wreg(`IDX_SECOND_PORT_DATA, 8'h00);
        wreg(`IDX_SECOND_PORT_DIR, 8'h7F);
        repeat (4) @(posedge pclk);
        rreg(`IDX_SECOND_PORT_DATA, rd);
        wreg(`IDX_INTERRUPT_CONTROL, 8'h08);
        wreg(`IDX_SECOND_PORT_DATA, 8'h80);
        repeat (4) @(posedge pclk);
        `CHK("b7_out", 1'b1, pb[7])
        `CHK("flag_excluded", 1'b0, port_change_flag)
        end_of_test();
    end
endmodule

// >>> verilog/three_port_gpio.sv
// Function
// - First port six bits, bits 7:6 absent
// - Direction one is input, zero drives latch
// - Data read gives pins, write loads latch
// - Writes sample pins, modify, store latch
// - First port bit 4 timer clock, open drain
// - After reset analog pins read as zero
// - Three-bit analog select, resets to zero
// - Direction still drives pins in analog use
// - First port bit 5 is slave select
// - Second port eight bits with direction
// - Pull-up disable bit, when low, enables pull-ups on input pins only
// - Output pins lose their pull-up
// - Pull-ups off after reset
// - Only input pins 7:4 detect change
// - Mismatch against value latched at last data access sets flag
// - Change event can wake from sleep
// - Mismatch keeps setting flag until the second port data is accessed; a clear write alone does not end it
// - Second port bit 0 is external interrupt
// - Third port eight bits, shared with peripherals
// - Enabled peripheral overrides direction bit
// - Claimed pin unavailable as general I/O
// - Peripheral select picks data, gates enable
`timescale 1ns/10ps
`include "three_port_gpio_params.svh"

module three_port_gpio
    import three_port_gpio_pkg::*;
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Pins
    input  wire port_t         first_port_in,
    output port_drive_s        first_port_drive,
    input  wire port_t         second_port_in,
    output port_drive_s        second_port_drive,
    output port_t              second_port_pullup,
    input  wire port_t         third_port_in,
    output port_drive_s        third_port_drive,
    // Peripheral side
    input  wire periph_claim_s third_port_claim,
    output logic               timer_clock_pin,
    output logic               slave_select_pin,
    output logic               external_irq_pin,
    output port_t              third_port_periph_in,
    // Change detection and wake
    input  wire logic          sleep_mode,
    output logic               port_change_flag,
    output logic               wake_req
);

    port_t       pin_a_ff, pin_b_ff, pin_c_ff;
    port_t       lat_a_ff, lat_b_ff, lat_c_ff;
    port_t       dir_a_ff, dir_b_ff, dir_c_ff;
    port_t       option_ff;
    logic [2:0]  analog_sel_ff;
    logic [3:0]  cmp_b_ff;
    logic        flag_ff, chg_en_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff, pslverr_ff;
    port_drive_s drv_a_ff, drv_b_ff, drv_c_ff;
    port_t       pull_ff, periph_in_ff;
    logic        tclk_ff, ss_ff, irq_ff, wake_ff;

    logic [9:0]  idx;
    logic        word_ok, acc_go, wr_go, rd_go, mapped;
    port_t       analog_mask, rd_a, rd_b, rd_c, keep;
    port_t       nxt_drv_a_out, nxt_drv_a_oen, nxt_drv_c_out, nxt_drv_c_oen;
    logic [31:0] nxt_prdata;
    logic [3:0]  mismatch;
    logic        chg_any, flag_clr, b_touch;

    // Bus decode
    assign idx     = paddr[11:2];
    assign word_ok = (paddr[1:0] == 2'h0);
    assign acc_go  = psel & penable & pready_ff;
    assign wr_go   = acc_go & pwrite & mapped & pstrb[0];
    assign rd_go   = acc_go & ~pwrite & mapped;
    assign keep    = pstrb[1] ? pwdata[`KEEP_MASK_LSB +: 8] : 8'h00;

    // Analog pins 0..3 and 5, fewer as the code rises
    function automatic port_t analog_decode(input logic [2:0] code);
        port_t m;
        logic [2:0] n;
        m = 8'h00;
        n = (code >= `PIN_ANALOG_CODE_ALL_DIG) ? 3'h0 : 3'(`PIN_ANALOG_CODE_ALL_DIG - code);
        if (n > 3'h0) m[0] = 1'b1;
        if (n > 3'h1) m[1] = 1'b1;
        if (n > 3'h2) m[2] = 1'b1;
        if (n > 3'h3) m[3] = 1'b1;
        if (n > 3'h4) m[5] = 1'b1;
        return m;
    endfunction

    assign analog_mask = analog_decode(analog_sel_ff);

    // Read values of the data registers
    assign rd_a = pin_a_ff & ~analog_mask & `FIRST_PORT_MASK;
    assign rd_b = pin_b_ff;
    assign rd_c = pin_c_ff;

    always_comb begin
        mapped     = word_ok;
        nxt_prdata = 32'h0000_0000;
        unique case (idx)
            10'(`IDX_FIRST_PORT_DATA):    nxt_prdata[7:0] = rd_a;
            10'(`IDX_SECOND_PORT_DATA):   nxt_prdata[7:0] = rd_b;
            10'(`IDX_THIRD_PORT_DATA):    nxt_prdata[7:0] = rd_c;
            10'(`IDX_INTERRUPT_CONTROL): begin
                nxt_prdata[`BIT_PORT_CHANGE_FLAG]   = flag_ff;
                nxt_prdata[`BIT_PORT_CHANGE_ENABLE] = chg_en_ff;
            end
            10'(`IDX_OPTION_SETTINGS):    nxt_prdata[7:0] = option_ff;
            10'(`IDX_FIRST_PORT_DIR):     nxt_prdata[7:0] = dir_a_ff & `FIRST_PORT_MASK;
            10'(`IDX_SECOND_PORT_DIR):    nxt_prdata[7:0] = dir_b_ff;
            10'(`IDX_THIRD_PORT_DIR):     nxt_prdata[7:0] = dir_c_ff;
            10'(`IDX_CONVERTER_CTRL_ONE): nxt_prdata[2:0] = analog_sel_ff;
            default:                      mapped = 1'b0;
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= ~mapped;
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Pin sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_ff <= 8'h00;
            pin_b_ff <= 8'h00;
            pin_c_ff <= 8'h00;
        end else begin
            pin_a_ff <= first_port_in & `FIRST_PORT_MASK;
            pin_b_ff <= second_port_in;
            pin_c_ff <= third_port_in;
        end
    end

    // Output latches: sampled pins where kept, written data elsewhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_a_ff <= `RST_PORT_LATCH;
            lat_b_ff <= `RST_PORT_LATCH;
            lat_c_ff <= `RST_PORT_LATCH;
        end else if (wr_go) begin
            if (idx == 10'(`IDX_FIRST_PORT_DATA))
                lat_a_ff <= ((keep & rd_a) | (~keep & pwdata[7:0])) & `FIRST_PORT_MASK;
            if (idx == 10'(`IDX_SECOND_PORT_DATA))
                lat_b_ff <= (keep & rd_b) | (~keep & pwdata[7:0]);
            if (idx == 10'(`IDX_THIRD_PORT_DATA))
                lat_c_ff <= (keep & rd_c) | (~keep & pwdata[7:0]);
        end
    end

    // Direction, option and analog select registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_a_ff      <= `RST_FIRST_PORT_DIR;
            dir_b_ff      <= `RST_SECOND_PORT_DIR;
            dir_c_ff      <= `RST_THIRD_PORT_DIR;
            option_ff     <= `RST_OPTION_SETTINGS;
            analog_sel_ff <= `RST_PIN_ANALOG_SELECT;
        end else if (wr_go) begin
            unique case (idx)
                10'(`IDX_FIRST_PORT_DIR):     dir_a_ff <= pwdata[7:0] & `FIRST_PORT_MASK;
                10'(`IDX_SECOND_PORT_DIR):    dir_b_ff <= pwdata[7:0];
                10'(`IDX_THIRD_PORT_DIR):     dir_c_ff <= pwdata[7:0];
                10'(`IDX_OPTION_SETTINGS):    option_ff <= pwdata[7:0];
                10'(`IDX_CONVERTER_CTRL_ONE): analog_sel_ff <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Change detection on upper second-port pins
    assign b_touch  = acc_go & mapped & (idx == 10'(`IDX_SECOND_PORT_DATA)) & (~pwrite | pstrb[0]);
    assign mismatch = (pin_b_ff[7:4] ^ cmp_b_ff) & dir_b_ff[7:4];
    assign chg_any  = |mismatch;
    assign flag_clr = wr_go & (idx == 10'(`IDX_INTERRUPT_CONTROL)) & ~pwdata[`BIT_PORT_CHANGE_FLAG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_b_ff <= 4'h0;
        end else if (b_touch) begin
            cmp_b_ff <= pin_b_ff[7:4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        end else if (chg_any) begin
            flag_ff <= 1'b1;
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_en_ff <= 1'b0;
        end else if (wr_go && idx == 10'(`IDX_INTERRUPT_CONTROL)) begin
            chg_en_ff <= pwdata[`BIT_PORT_CHANGE_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= sleep_mode & chg_en_ff & (flag_ff | chg_any);
        end
    end

    // First port drive
    always_comb begin
        nxt_drv_a_out = lat_a_ff & `FIRST_PORT_MASK;
        nxt_drv_a_oen = dir_a_ff | ~`FIRST_PORT_MASK;
        nxt_drv_a_out[`BIT_TIMER_CLOCK_PIN] = 1'b0;
        nxt_drv_a_oen[`BIT_TIMER_CLOCK_PIN] = dir_a_ff[`BIT_TIMER_CLOCK_PIN] | lat_a_ff[`BIT_TIMER_CLOCK_PIN];
    end

    // Third port drive with peripheral override
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (third_port_claim.sel[i]) begin
                nxt_drv_c_out[i] = third_port_claim.out[i];
                nxt_drv_c_oen[i] = ~third_port_claim.oe[i];
            end else begin
                nxt_drv_c_out[i] = lat_c_ff[i];
                nxt_drv_c_oen[i] = dir_c_ff[i];
            end
        end
    end

    // Registered pin and peripheral outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_a_ff     <= '{out: 8'h00, oe_n: 8'hFF};
            drv_b_ff     <= '{out: 8'h00, oe_n: 8'hFF};
            drv_c_ff     <= '{out: 8'h00, oe_n: 8'hFF};
            pull_ff      <= 8'h00;
            periph_in_ff <= 8'h00;
            tclk_ff      <= 1'b0;
            ss_ff        <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            drv_a_ff     <= '{out: nxt_drv_a_out, oe_n: nxt_drv_a_oen};
            drv_b_ff     <= '{out: lat_b_ff, oe_n: dir_b_ff};
            drv_c_ff     <= '{out: nxt_drv_c_out, oe_n: nxt_drv_c_oen};
            pull_ff      <= {8{~option_ff[`BIT_PULLUP_DISABLE_N]}} & dir_b_ff;
            periph_in_ff <= pin_c_ff;
            tclk_ff      <= pin_a_ff[`BIT_TIMER_CLOCK_PIN];
            ss_ff        <= pin_a_ff[`BIT_SLAVE_SELECT_PIN];
            irq_ff       <= pin_b_ff[`BIT_EXTERNAL_IRQ_PIN];
        end
    end

    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign first_port_drive     = drv_a_ff;
    assign second_port_drive    = drv_b_ff;
    assign second_port_pullup   = pull_ff;
    assign third_port_drive     = drv_c_ff;
    assign third_port_periph_in = periph_in_ff;
    assign timer_clock_pin      = tclk_ff;
    assign slave_select_pin     = ss_ff;
    assign external_irq_pin     = irq_ff;
    assign port_change_flag     = flag_ff;
    assign wake_req             = wake_ff;

    // Checks
    property p_upper_a_never_driven;
        @(posedge pclk) disable iff (!presetn)
        drv_a_ff.oe_n[7:6] == 2'b11;
    endproperty
    a_upper_a_never_driven: assert property (p_upper_a_never_driven) else $error("upper first-port pins driven");

    property p_b_drive_follows_dir;
        @(posedge pclk) disable iff (!presetn)
        ##1 drv_b_ff.oe_n == $past(dir_b_ff) && drv_b_ff.out == $past(lat_b_ff);
    endproperty
    a_b_drive_follows_dir: assert property (p_b_drive_follows_dir) else $error("second port drive wrong");

    property p_read_a_masked;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_ff && !pwrite && word_ok && idx == 10'(`IDX_FIRST_PORT_DATA))
        |=> (prdata_ff[7:0] & $past(analog_mask)) == 8'h00 && prdata_ff[7:6] == 2'b00;
    endproperty
    a_read_a_masked: assert property (p_read_a_masked) else $error("analog pin read not zero");

    property p_timer_pin_open_drain;
        @(posedge pclk) disable iff (!presetn)
        !drv_a_ff.oe_n[`BIT_TIMER_CLOCK_PIN] |-> !drv_a_ff.out[`BIT_TIMER_CLOCK_PIN];
    endproperty
    a_timer_pin_open_drain: assert property (p_timer_pin_open_drain) else $error("timer pin driven high");

    property p_pullup_off_on_output;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((pull_ff & ~$past(dir_b_ff)) == 8'h00) && (!$past(option_ff[`BIT_PULLUP_DISABLE_N]) || pull_ff == 8'h00);
    endproperty
    a_pullup_off_on_output: assert property (p_pullup_off_on_output) else $error("pull-up on where it must be off");

    property p_mismatch_sets_flag;
        @(posedge pclk) disable iff (!presetn)
        chg_any |=> flag_ff;
    endproperty
    a_mismatch_sets_flag: assert property (p_mismatch_sets_flag) else $error("mismatch did not set flag");

    property p_flag_needs_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(flag_ff) |-> $past(chg_any);
    endproperty
    a_flag_needs_cause: assert property (p_flag_needs_cause) else $error("flag set without mismatch");

    property p_output_pins_no_change;
        @(posedge pclk) disable iff (!presetn)
        (dir_b_ff[7:4] == 4'h0) |-> !chg_any;
    endproperty
    a_output_pins_no_change: assert property (p_output_pins_no_change) else $error("output pin caused change");

    property p_read_relatches;
        @(posedge pclk) disable iff (!presetn)
        b_touch |=> cmp_b_ff == $past(pin_b_ff[7:4]);
    endproperty
    a_read_relatches: assert property (p_read_relatches) else $error("compare value not relatched");

    property p_override_c;
        @(posedge pclk) disable iff (!presetn)
        third_port_claim.sel[0] |=> drv_c_ff.oe_n[0] == !$past(third_port_claim.oe[0])
                                    && drv_c_ff.out[0] == $past(third_port_claim.out[0]);
    endproperty
    a_override_c: assert property (p_override_c) else $error("peripheral override not applied");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleep_mode && chg_en_ff && chg_any) |=> wake_ff;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on change");

    property p_apb_one_wait;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_ff) |=> pready_ff ##1 !pready_ff;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("bad answer timing");

endmodule
